// File: mfc_consts.svh
`ifndef MFC_CONSTS_SVH
`define MFC_CONSTS_SVH
// register word indices (byte address is four times the index)
`define MFC_IDX_FAULT_CFG   8'h94
`define MFC_IDX_STATUS      8'hB0
`define MFC_IDX_MASK        8'hB1
`define MFC_IDX_MEAS        8'hB2
`define MFC_IDX_CTRL        8'hB3
`define MFC_FAULT_CFG_RST   32'h0000_0000
// field positions
`define MFC_B_PARITY        31
`define MFC_B_ABN_EN        30
`define MFC_B_SYNC_EN       29
`define MFC_B_NOMTR_EN      28
`define MFC_F_ABN_LIM       27:24
`define MFC_F_SYNC_CNT      23:21
`define MFC_F_NOMTR_LIM     20:18
`define MFC_B_OV_MODE       17
`define MFC_F_MAX_SUP       16:14
`define MFC_B_UV_MODE       13
`define MFC_F_MIN_SUP       12:10
`define MFC_F_RETRY         9:7
`define MFC_F_LOCK_MIN      6:4
`define MFC_F_JUMP          3:2
`define MFC_F_ZERO_DUTY     1:0
// status / mask bits
`define MFC_NUM_EV          7
`define MFC_EV_ABN          0
`define MFC_EV_SYNC         1
`define MFC_EV_NOMTR        2
`define MFC_EV_OV           3
`define MFC_EV_UV           4
`define MFC_EV_LOCK         5
`define MFC_EV_JUMP         6
// ctrl bits
`define MFC_C_CLR_LOCK      0
`define MFC_C_CLR_OV        1
`define MFC_C_CLR_UV        2
// lock retry wait, 100 ms at 40 ns per cycle
`define MFC_RETRY_MS        100
`define MFC_CLK_NS          40
`endif

// File: mfc_pkg.sv
package mfc_pkg;
   typedef enum logic [1:0] {MFC_RUN, MFC_LOCK_WAIT, MFC_LOCK_HELD} mfc_lock_state_t;
endpackage

// File: mfc_sync.sv
module mfc_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_nrst,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta;
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         meta <= '0;
         o_q  <= '0;
      end else begin
         meta <= i_d;
         o_q  <= meta;
      end
   end
endmodule

// File: mfc_fault_bank.sv
// The address map and strobed register access were decided locally.
`include "mfc_consts.svh"
module mfc_fault_bank #(
   parameter int RETRY_CYCLES = (`MFC_RETRY_MS * 1000000) / `MFC_CLK_NS
) (
   // clock and reset
   input  wire logic        I_CLOCK,
   input  wire logic        I_NRST,
   // register port
   input  wire logic [7:0]  I_ADDR,
   input  wire logic [31:0] I_WDATA,
   input  wire logic        I_WR,
   input  wire logic        I_RD,
   output logic      [31:0] O_RDATA,
   // measurements: speed in 0.5 Hz units, supply in 0.1 V, sense in 0.1 mV, duty in 0.1 %
   input  wire logic [15:0] I_SPEED,
   input  wire logic        I_CYCLE_DONE,
   input  wire logic        I_SYNC_LOST,
   input  wire logic [9:0]  I_SUPPLY,
   input  wire logic [9:0]  I_SENSE,
   input  wire logic [9:0]  I_DUTY,
   input  wire logic        I_AUTO_RECOVER,
   input  wire logic        I_RUNNING,
   // outputs
   output logic             O_ZERO_TARGET,
   output logic             O_GATE_HOLD,
   output logic             O_RETRY,
   output logic             O_FAULT,
   output logic             O_IRQ
);
   logic [31:0] cfg;
   logic [`MFC_NUM_EV-1:0] status;
   logic [`MFC_NUM_EV-1:0] mask;
   logic [15:0] speed_s;
   logic [15:0] prev_speed;
   logic [2:0]  pins_s;
   logic [9:0]  supply_s;
   logic [9:0]  sense_s;
   logic [9:0]  duty_s;
   logic [3:0]  sync_cnt;
   logic [4:0]  retry_cnt;
   logic [31:0] wait_cnt;
   logic        ov_flag;
   logic        uv_flag;
   logic        lock_flag;
   mfc_pkg::mfc_lock_state_t lock_st;
   mfc_pkg::mfc_lock_state_t next_lock_st;

   // pins from outside the clock domain go through two flops
   mfc_sync #(.W(16)) u_sync_speed (.i_clk(I_CLOCK), .i_nrst(I_NRST), .i_d(I_SPEED),
                                   .o_q(speed_s));
   mfc_sync #(.W(30)) u_sync_meas (.i_clk(I_CLOCK), .i_nrst(I_NRST),
                                  .i_d({I_SUPPLY, I_SENSE, I_DUTY}),
                                  .o_q({supply_s, sense_s, duty_s}));
   mfc_sync #(.W(3)) u_sync_ev (.i_clk(I_CLOCK), .i_nrst(I_NRST),
                               .i_d({I_CYCLE_DONE, I_SYNC_LOST, I_RUNNING}),
                               .o_q(pins_s));
   logic cyc_lvl_d;
   logic sync_lvl_d;
   wire  cyc_ev  = pins_s[2] & ~cyc_lvl_d;
   wire  sync_ev = pins_s[1] & ~sync_lvl_d;
   wire  running = pins_s[0];

   // field decode
   wire        abn_en   = cfg[`MFC_B_ABN_EN];
   wire        sync_en  = cfg[`MFC_B_SYNC_EN];
   wire        nomtr_en = cfg[`MFC_B_NOMTR_EN];
   // 250 Hz steps as 0.5 Hz units: 500 * (code + 1)
   wire [15:0] abn_lim  = 16'(({12'h000, cfg[`MFC_F_ABN_LIM]} + 16'h0001) * 16'h01F4);
   wire [3:0]  sync_need = {1'b0, cfg[`MFC_F_SYNC_CNT]} + 4'h2;

   logic [9:0] nomtr_lim;
   logic [9:0] max_sup;
   logic [9:0] min_sup;
   logic [4:0] retry_max;
   logic [15:0] lock_min;
   logic [3:0] jump_ratio;
   logic [9:0] zero_duty;
   always_comb begin
      case (cfg[`MFC_F_NOMTR_LIM])
         3'h0: nomtr_lim = 10'h032;
         3'h1: nomtr_lim = 10'h04B;
         3'h2: nomtr_lim = 10'h064;
         3'h3: nomtr_lim = 10'h07D;
         3'h4: nomtr_lim = 10'h0C8;
         3'h5: nomtr_lim = 10'h0FA;
         3'h6: nomtr_lim = 10'h12C;
         default: nomtr_lim = 10'h190;
      endcase
   end

   always_comb begin
      case (cfg[`MFC_F_MAX_SUP])
         3'h1: max_sup = 10'h064;
         3'h2: max_sup = 10'h096;
         3'h3: max_sup = 10'h0DC;
         3'h4: max_sup = 10'h140;
         3'h5: max_sup = 10'h190;
         3'h6: max_sup = 10'h1F4;
         3'h7: max_sup = 10'h258;
         default: max_sup = 10'h3FF;
      endcase
   end

   always_comb begin
      case (cfg[`MFC_F_MIN_SUP])
         3'h1: min_sup = 10'h032;
         3'h2: min_sup = 10'h03C;
         3'h3: min_sup = 10'h046;
         3'h4: min_sup = 10'h050;
         3'h5: min_sup = 10'h064;
         3'h6: min_sup = 10'h078;
         3'h7: min_sup = 10'h096;
         default: min_sup = 10'h000;
      endcase
   end

   always_comb begin
      case (cfg[`MFC_F_RETRY])
         3'h1: retry_max = 5'h02;
         3'h2: retry_max = 5'h03;
         3'h3: retry_max = 5'h05;
         3'h4: retry_max = 5'h07;
         3'h5: retry_max = 5'h0A;
         3'h6: retry_max = 5'h0F;
         3'h7: retry_max = 5'h14;
         default: retry_max = 5'h00;
      endcase
   end

   always_comb begin
      case (cfg[`MFC_F_LOCK_MIN])
         3'h0: lock_min = 16'h0001;
         3'h1: lock_min = 16'h0002;
         3'h2: lock_min = 16'h0004;
         3'h3: lock_min = 16'h0006;
         3'h4: lock_min = 16'h000A;
         3'h5: lock_min = 16'h0014;
         3'h6: lock_min = 16'h001E;
         default: lock_min = 16'h0032;
      endcase
   end

   always_comb begin
      case (cfg[`MFC_F_JUMP])
         2'h0: jump_ratio = 4'h2;
         2'h1: jump_ratio = 4'h4;
         2'h2: jump_ratio = 4'h6;
         default: jump_ratio = 4'h8;
      endcase
   end

   always_comb begin
      case (cfg[`MFC_F_ZERO_DUTY])
         2'h0: zero_duty = 10'h000;
         2'h1: zero_duty = 10'h00A;
         2'h2: zero_duty = 10'h014;
         default: zero_duty = 10'h019;
      endcase
   end

   // detectors; speed, sense and lock comparisons only while running to avoid startup false trips
   wire ev_abn   = abn_en & running & (speed_s > abn_lim);
   wire ev_sync  = sync_en & sync_ev & ((sync_cnt + 4'h1) >= sync_need);
   wire ev_nomtr = nomtr_en & running & (sense_s < nomtr_lim);
   wire ov_now   = (cfg[`MFC_F_MAX_SUP] != 3'h0) & (supply_s > max_sup);
   wire uv_now   = (cfg[`MFC_F_MIN_SUP] != 3'h0) & (supply_s < min_sup);
   wire slow     = running & (speed_s < lock_min);
   // ratio check both ways, widened so the product cannot overflow
   wire [19:0] prev_x = 20'(prev_speed * jump_ratio);
   wire [19:0] cur_x  = 20'(speed_s * jump_ratio);
   wire ev_jump = running & cyc_ev & (prev_speed != 16'h0000) &
                  ((20'(speed_s) > prev_x) | (20'(prev_speed) > cur_x));
   wire lock_ev = slow | ev_jump;
   assign O_ZERO_TARGET = (duty_s < zero_duty);

   // unmapped indices hit nothing: reads give zero, writes drop
   // register decode
   wire hit_cfg  = (I_ADDR == `MFC_IDX_FAULT_CFG);
   wire hit_stat = (I_ADDR == `MFC_IDX_STATUS);
   wire hit_mask = (I_ADDR == `MFC_IDX_MASK);
   wire hit_meas = (I_ADDR == `MFC_IDX_MEAS);
   wire hit_ctrl = (I_ADDR == `MFC_IDX_CTRL);
   wire ctrl_wr  = I_WR & hit_ctrl;
   wire clr_lock = ctrl_wr & I_WDATA[`MFC_C_CLR_LOCK];
   wire clr_ov   = ctrl_wr & I_WDATA[`MFC_C_CLR_OV];
   wire clr_uv   = ctrl_wr & I_WDATA[`MFC_C_CLR_UV];
   wire [31:0] rd_mux =
      hit_cfg  ? cfg :
      hit_stat ? {25'h0, status} :
      hit_mask ? {25'h0, mask} :
      hit_meas ? {29'h0, lock_flag, uv_flag, ov_flag} :
      32'h0000_0000;

   wire [`MFC_NUM_EV-1:0] ev_vec = {ev_jump, lock_ev & (lock_st == mfc_pkg::MFC_RUN),
                                    uv_now & ~uv_flag, ov_now & ~ov_flag,
                                    ev_nomtr, ev_sync, ev_abn};

   // set wins over the write-one clear
   genvar g;
   generate
      for (g = 0; g < `MFC_NUM_EV; g++) begin : g_stat
         always_ff @(posedge I_CLOCK) begin
            if (!I_NRST) status[g] <= 1'b0;
            else if (ev_vec[g]) status[g] <= 1'b1;
            else if (I_WR & hit_stat & I_WDATA[g]) status[g] <= 1'b0;
         end
      end
   endgenerate

   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         cfg     <= `MFC_FAULT_CFG_RST;
         mask    <= '0;
         O_RDATA <= 32'h0000_0000;
      end else begin
         if (I_WR & hit_cfg) cfg <= I_WDATA;
         if (I_WR & hit_mask) mask <= I_WDATA[`MFC_NUM_EV-1:0];
         O_RDATA <= I_RD ? rd_mux : 32'h0000_0000;
      end
   end

   // supply faults: latched until cleared, or auto-clear when in bounds
   // a clear that meets a still-present condition loses, so the flag re-sets
   wire next_ov = ov_now | (ov_flag & ~cfg[`MFC_B_OV_MODE] & ~clr_ov);
   wire next_uv = uv_now | (uv_flag & ~cfg[`MFC_B_UV_MODE] & ~clr_uv);

   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         ov_flag    <= 1'b0;
         uv_flag    <= 1'b0;
         cyc_lvl_d  <= 1'b0;
         sync_lvl_d <= 1'b0;
         prev_speed <= 16'h0000;
         sync_cnt   <= 4'h0;
      end else begin
         ov_flag    <= next_ov;
         uv_flag    <= next_uv;
         cyc_lvl_d  <= pins_s[2];
         sync_lvl_d <= pins_s[1];
         if (cyc_ev) prev_speed <= speed_s;
         if (!sync_en || ev_sync) sync_cnt <= 4'h0;
         else if (sync_ev) sync_cnt <= sync_cnt + 4'h1;
      end
   end

   // lock handling
   // retry cap code zero means retries never run out
   wire retries_left = (retry_max == 5'h00) | (retry_cnt < retry_max);
   // wait length is fixed here; its selector lives in another register
   wire wait_done    = (wait_cnt >= 32'(RETRY_CYCLES - 1));
   always_comb begin
      next_lock_st = lock_st;
      case (lock_st)
         mfc_pkg::MFC_RUN:
            if (lock_ev) begin
               if (I_AUTO_RECOVER && retries_left) next_lock_st = mfc_pkg::MFC_LOCK_WAIT;
               else next_lock_st = mfc_pkg::MFC_LOCK_HELD;
            end
         mfc_pkg::MFC_LOCK_WAIT:
            if (wait_done) next_lock_st = mfc_pkg::MFC_RUN;
         mfc_pkg::MFC_LOCK_HELD:
            if (clr_lock) next_lock_st = mfc_pkg::MFC_RUN;
         default: next_lock_st = mfc_pkg::MFC_RUN;
      endcase
   end

   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         lock_st   <= mfc_pkg::MFC_RUN;
         wait_cnt  <= 32'h0000_0000;
         retry_cnt <= 5'h00;
         O_RETRY   <= 1'b0;
      end else begin
         lock_st  <= next_lock_st;
         wait_cnt <= (lock_st == mfc_pkg::MFC_LOCK_WAIT) ? wait_cnt + 32'h1 : 32'h0;
         O_RETRY  <= (lock_st == mfc_pkg::MFC_LOCK_WAIT) && wait_done;
         if (clr_lock) retry_cnt <= 5'h00;
         else if ((lock_st == mfc_pkg::MFC_LOCK_WAIT) && wait_done && retry_cnt != 5'h1F)
            retry_cnt <= retry_cnt + 5'h01;
      end
   end

   assign lock_flag   = (lock_st != mfc_pkg::MFC_RUN);
   assign O_GATE_HOLD = lock_flag;
   assign O_FAULT     = lock_flag | ov_flag | uv_flag;
   assign O_IRQ       = |(status & mask);
endmodule

// File: mfc_fault_bank_props.sv
`include "mfc_consts.svh"
module mfc_fault_bank_props #(
   parameter int RETRY_CYCLES = 8
) (
   input  wire logic        I_CLOCK,
   input  wire logic        I_NRST,
   input  wire logic [7:0]  I_ADDR,
   input  wire logic [31:0] I_WDATA,
   input  wire logic        I_WR,
   input  wire logic        I_RD,
   input  wire logic [9:0]  I_DUTY,
   input  wire logic [31:0] O_RDATA,
   input  wire logic        O_ZERO_TARGET,
   input  wire logic        O_GATE_HOLD,
   input  wire logic        O_RETRY,
   input  wire logic        O_FAULT,
   input  wire logic        O_IRQ
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] cfg;
   logic [6:0]  mask;
   int          hold_cnt;
   wire         clr_lock = I_WR && I_ADDR == `MFC_IDX_CTRL && I_WDATA[`MFC_C_CLR_LOCK];
   // longer than any retry wait, so only a held lock gets here
   wire         held_long = O_GATE_HOLD && hold_cnt > RETRY_CYCLES;
   wire  [1:0]  zd = cfg[`MFC_F_ZERO_DUTY];
   wire  [9:0]  duty_lim = (zd == 2'h0) ? 10'h000 : (zd == 2'h1) ? 10'h00A :
                           (zd == 2'h2) ? 10'h014 : 10'h019;
   wire         mapped = I_ADDR == `MFC_IDX_FAULT_CFG || (I_ADDR >= `MFC_IDX_STATUS &&
                         I_ADDR <= `MFC_IDX_CTRL);
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         cfg      <= `MFC_FAULT_CFG_RST;
         mask     <= 7'h00;
         hold_cnt <= 0;
      end else begin
         if (I_WR && I_ADDR == `MFC_IDX_FAULT_CFG) cfg <= I_WDATA;
         if (I_WR && I_ADDR == `MFC_IDX_MASK) mask <= I_WDATA[6:0];
         hold_cnt <= O_GATE_HOLD ? hold_cnt + 1 : 0;
      end
   end
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (!I_NRST);
   cfg_readback_a: assert property (I_RD && I_ADDR == `MFC_IDX_FAULT_CFG |=>
      O_RDATA == cfg) else $error("config readback differs");
   rdata_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
      else $error("read data without read");
   unmapped_zero_a: assert property (I_RD && !mapped |=> O_RDATA == 32'h0)
      else $error("unmapped read not zero");
   zero_duty_a: assert property (O_ZERO_TARGET == ($past(I_DUTY, 2) < duty_lim))
      else $error("zero target wrong");
   irq_masked_a: assert property (O_IRQ |-> mask != 7'h00)
      else $error("irq while all masked");
   retry_pulse_a: assert property (O_RETRY |=> !O_RETRY)
      else $error("retry pulse too long");
   retry_wait_a: assert property (O_RETRY |-> hold_cnt >= RETRY_CYCLES - 1 &&
      hold_cnt <= RETRY_CYCLES + 1) else $error("retry wait length wrong");
   hold_fault_a: assert property ($rose(O_GATE_HOLD) |-> ##[0:1] O_FAULT)
      else $error("lock hold without fault");
   held_latch_a: assert property (held_long && !clr_lock |=> O_GATE_HOLD)
      else $error("held lock released without clear");
   cover property (O_RETRY);
   cover property (O_IRQ);
   cover property (O_ZERO_TARGET);
   cover property (held_long);
endmodule
bind mfc_fault_bank mfc_fault_bank_props #(.RETRY_CYCLES(RETRY_CYCLES)) u_props (
   .I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
   .I_RD(I_RD), .I_DUTY(I_DUTY), .O_RDATA(O_RDATA), .O_ZERO_TARGET(O_ZERO_TARGET),
   .O_GATE_HOLD(O_GATE_HOLD), .O_RETRY(O_RETRY), .O_FAULT(O_FAULT), .O_IRQ(O_IRQ));

// File: mfc_motor_model.sv
module mfc_motor_model (
   // clock and commanded conditions
   input  wire logic        i_clk,
   input  wire logic [15:0] i_speed,
   input  wire logic [9:0]  i_supply,
   input  wire logic [9:0]  i_duty,
   input  wire logic        i_run,
   input  wire logic        i_slip,
   input  wire logic [9:0]  i_sense,
   // measured lines
   output logic      [15:0] o_speed = 16'h0000,
   output logic             o_cycle = 1'b0,
   output logic             o_lost = 1'b0,
   output logic      [9:0]  o_supply = 10'h050,
   output logic      [9:0]  o_duty = 10'h000,
   output logic             o_run = 1'b0,
   output logic      [9:0]  o_sense = 10'h3FF
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase = 2'h0;
   // one electrical cycle per four clocks, only while driven
   always @(posedge i_clk) begin
      phase    <= phase + 2'h1;
      o_cycle  <= i_run && phase[1];
      o_speed  <= i_speed;
      o_lost   <= i_slip;
      o_supply <= i_supply;
      o_duty   <= i_duty;
      o_run    <= i_run;
      o_sense  <= i_sense;
   end
endmodule

// File: mfc_fault_bank_tb.sv
`include "mfc_consts.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end
module mfc_fault_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, exp_v, r;
   logic [15:0] speed = 16'h0000, m_speed;
   logic [9:0]  supply = 10'h050, duty = 10'h000, m_sup, m_duty;
   logic [9:0]  sense = 10'h3FF, m_sense;
   logic        run = 1'b0, slip = 1'b0, auto_rec = 1'b0, m_cyc, m_lost, m_run;
   logic        zero_t, hold, retry, fault, irq;
   logic [31:0] expq[$], seed = 32'h0000_459E;
   int          errors = 0, comparisons = 0;
   logic [7:0]  n;
   logic [9:0]  lim[4] = '{10'h000, 10'h00A, 10'h014, 10'h019};
   logic [31:0] sup_cfg[4] = '{32'h0000_0400, 32'h0000_2400, 32'h0002_4000, 32'h0000_4000};
   logic [9:0]  sup_bad[4] = '{10'h028, 10'h028, 10'h096, 10'h096};
   logic [31:0] sup_meas[4] = '{32'h2, 32'h0, 32'h0, 32'h1};
   always #20 clk = ~clk;
   mfc_motor_model u_motor (.i_clk(clk), .i_speed(speed), .i_supply(supply), .i_duty(duty),
      .i_run(run), .i_slip(slip), .i_sense(sense), .o_speed(m_speed), .o_cycle(m_cyc),
      .o_lost(m_lost), .o_supply(m_sup), .o_duty(m_duty), .o_run(m_run),
      .o_sense(m_sense));
   mfc_fault_bank #(.RETRY_CYCLES(8)) dut (.I_CLOCK(clk), .I_NRST(nrst), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SPEED(m_speed),
      .I_CYCLE_DONE(m_cyc), .I_SYNC_LOST(m_lost), .I_SUPPLY(m_sup), .I_SENSE(m_sense),
      .I_DUTY(m_duty), .I_AUTO_RECOVER(auto_rec), .I_RUNNING(m_run),
      .O_ZERO_TARGET(zero_t), .O_GATE_HOLD(hold), .O_RETRY(retry), .O_FAULT(fault), .O_IRQ(irq));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // strobes are only ever set here, so each step assigns them once
   task automatic bus(input logic w, input logic rr, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] e);
      wr <= w;
      rd <= rr;
      addr <= a;
      wdata <= d;
      if (rr) expq.push_back(e);
      @(posedge clk);
   endtask
   task automatic idle(input int k);
      bus(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
      repeat (k - 1) @(posedge clk);
   endtask
   task automatic do_reset();
      nrst <= 1'b0;
      idle(4);
      nrst <= 1'b1;
      idle(3);
      bus(1'b0, 1'b1, `MFC_IDX_FAULT_CFG, 32'h0, `MFC_FAULT_CFG_RST);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk) rd_d <= rd;
   always @(negedge clk) begin
      if (rd_d && expq.size() > 0) begin
         exp_v = expq.pop_front();
         `CHK("rdata", exp_v, rdata)
      end
   end
   initial begin
      do_reset();
      bus(1'b1, 1'b0, 8'h10, 32'hFFFF_FFFF, 32'h0);
      bus(1'b0, 1'b1, 8'h10, 32'h0, 32'h0);
      for (int i = 0; i < 6; i++) begin
         r = xs();
         bus(1'b1, 1'b0, `MFC_IDX_FAULT_CFG, r, 32'h0);
         bus(1'b0, 1'b1, `MFC_IDX_FAULT_CFG, 32'h0, r);
      end
      do_reset();
      foreach (lim[k]) begin
         bus(1'b1, 1'b0, `MFC_IDX_FAULT_CFG, k, 32'h0);
         duty <= lim[k] - 10'h001;
         idle(5);
         `CHK("zero_below", k != 0, zero_t)
         duty <= lim[k];
         idle(5);
         `CHK("zero_at", 1'b0, zero_t)
      end
      bus(1'b1, 1'b0, `MFC_IDX_MASK, 32'h7F, 32'h0);
      for (int en = 1; en >= 0; en--) begin
         bus(1'b1, 1'b0, `MFC_IDX_FAULT_CFG, {2'h0, en[0], 29'h0020_0000}, 32'h0);
         for (int i = 1; i <= 3; i++) begin
            slip <= 1'b1;
            idle(2);
            slip <= 1'b0;
            idle(4);
            `CHK("sync_irq", en == 1 && i == 3, irq)
         end
         bus(1'b0, 1'b1, `MFC_IDX_STATUS, 32'h0, en == 1 ? 32'h2 : 32'h0);
         bus(1'b1, 1'b0, `MFC_IDX_STATUS, 32'h7F, 32'h0);
      end
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 1'b0, `MFC_IDX_FAULT_CFG, sup_cfg[i], 32'h0);
         supply <= sup_bad[i];
         idle(6);
         `CHK("supply_fault", 1'b1, fault)
         supply <= 10'h050;
         idle(6);
         `CHK("supply_latch", i == 0 || i == 3, fault)
         bus(1'b0, 1'b1, `MFC_IDX_MEAS, 32'h0, sup_meas[i]);
         bus(1'b1, 1'b0, `MFC_IDX_CTRL, 32'h6, 32'h0);
         idle(3);
         `CHK("supply_clear", 1'b0, fault)
      end
      bus(1'b1, 1'b0, `MFC_IDX_MASK, 32'h0, 32'h0);
      idle(2);
      `CHK("irq_masked", 1'b0, irq)
      bus(1'b1, 1'b0, `MFC_IDX_STATUS, 32'h7F, 32'h0);
      bus(1'b1, 1'b0, `MFC_IDX_FAULT_CFG, 32'h0000_00F0, 32'h0);
      auto_rec <= 1'b1;
      run <= 1'b1;
      speed <= 16'h003C;
      idle(10);
      `CHK("lock_above_min", 1'b0, hold)
      speed <= 16'h0028;
      n = 8'h00;
      repeat (100) begin
         @(posedge clk);
         n += 8'(retry);
      end
      `CHK("retry_count", 8'h02, n)
      `CHK("lock_held", 1'b1, hold)
      run <= 1'b0;
      idle(3);
      bus(1'b1, 1'b0, `MFC_IDX_CTRL, 32'h1, 32'h0);
      idle(3);
      `CHK("lock_cleared", 1'b0, hold)
      // fresh reset so the previous speed sample cannot fake a jump
      do_reset();
      bus(1'b1, 1'b0, `MFC_IDX_FAULT_CFG, 32'h5000_0000, 32'h0);
      sense <= 10'h032;
      speed <= 16'h01F4;
      run <= 1'b1;
      idle(12);
      bus(1'b0, 1'b1, `MFC_IDX_STATUS, 32'h0, 32'h0);
      sense <= 10'h031;
      speed <= 16'h01F5;
      idle(8);
      bus(1'b0, 1'b1, `MFC_IDX_STATUS, 32'h0, 32'h5);
      bus(1'b1, 1'b0, `MFC_IDX_FAULT_CFG, 32'h0, 32'h0);
      bus(1'b1, 1'b0, `MFC_IDX_STATUS, 32'h7F, 32'h0);
      idle(4);
      bus(1'b0, 1'b1, `MFC_IDX_STATUS, 32'h0, 32'h0);
      speed <= 16'h00FB;
      idle(10);
      bus(1'b0, 1'b1, `MFC_IDX_STATUS, 32'h0, 32'h0);
      speed <= 16'h007D;
      idle(10);
      bus(1'b0, 1'b1, `MFC_IDX_STATUS, 32'h0, 32'h60);
      run <= 1'b0;
      idle(12);
      report_and_stop();
   end
endmodule
